// ---- inc/scsh_pkg.sv ----
// serial channel state handling: constants, register layouts and types
// assumes a byte-wide register port and a 100 MHz core_clk
`default_nettype none

package scsh_pkg;
  localparam int ADDR_W = 3;
  localparam int CNT_W  = 10;

  // register word indices
  localparam logic [ADDR_W-1:0] OFS_MODE  = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_BAUD  = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_TDATA = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_RDATA = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_PORT  = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_MSTOP = 3'h7;

  // reset values
  localparam logic [7:0] STAT_RST  = 8'h84;
  localparam logic [7:0] MSTOP_RST = 8'h01;

  // frame lengths, counted from zero; SYNC_BITS is the plain bit count
  localparam logic [3:0] ASYNC_LAST_NOPAR = 4'h9;
  localparam logic [3:0] ASYNC_LAST_PAR   = 4'ha;
  localparam logic [3:0] SYNC_LAST        = 4'h7;
  localparam logic [3:0] SYNC_BITS        = 4'h8;
  localparam logic [3:0] RX_LAST_NOPAR    = 4'h8;
  localparam logic [3:0] RX_LAST_PAR      = 4'h9;

  typedef struct packed {
    logic       sync_mode;
    logic       rsv6;
    logic       par_en;
    logic       par_odd;
    logic [3:0] rsv;
  } scsh_mode_type;

  typedef struct packed {
    logic       tx_irq_en;
    logic       rx_irq_en;
    logic       tx_enable_bit;
    logic       rx_enable_bit;
    logic       rsv3;
    logic       tx_done_irq_en;
    logic       clock_source_sel_hi;
    logic       clock_source_sel_lo;
  } scsh_ctrl_type;

  typedef struct packed {
    logic       tx_buffer_empty_flag;
    logic       rx_full_flag;
    logic       overrun_flag;
    logic       framing_error_flag;
    logic       parity_error_flag;
    logic       tx_end_flag;
    logic [1:0] rsv;
  } scsh_stat_type;

  typedef struct packed {
    logic       sck_dir;
    logic       sck_data;
    logic       txd_dir;
    logic       port_data_bit;
    logic [3:0] rsv;
  } scsh_port_type;

  typedef enum logic [2:0] {
    LP_ACTIVE, LP_SW_STANDBY, LP_SUB_SLEEP, LP_WATCH, LP_SUB_ACTIVE
  } scsh_lp_type;

  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction : parity_of

  // half a bit period minus one, in core cycles
  function automatic logic [CNT_W-1:0] half_m1(input logic [7:0] div);
    return {2'h0, div};
  endfunction : half_m1

  // a whole bit period minus one
  function automatic logic [CNT_W-1:0] full_m1(input logic [7:0] div);
    return {1'h0, div, 1'h1};
  endfunction : full_m1

  function automatic logic tx_reset_on(input scsh_lp_type lp);
    return lp inside {LP_SW_STANDBY, LP_SUB_SLEEP};
  endfunction : tx_reset_on

  function automatic logic rx_reset_on(input scsh_lp_type lp);
    return lp != LP_ACTIVE;
  endfunction : rx_reset_on
endpackage : scsh_pkg

`default_nettype wire

// ---- design/scsh_rx.sv ----
// serial channel receiver: start search, sampling, character assembly
// assumes rxd is already synchronised to core_clk and sync_rise is a pulse
`default_nettype none

module scsh_rx
  (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    // control
    input  wire logic                       clr,
    input  wire logic                       rx_en,
    input  wire logic                       sync_mode,
    input  wire logic                       par_en,
    input  wire logic                       par_odd,
    input  wire logic [7:0]                 baud_div,
    // line
    input  wire logic                       rxd,
    input  wire logic                       sync_rise,
    // results
    output logic                            done_r,
    output logic [7:0]                      data_r,
    output logic                            fer_r,
    output logic                            per_r
  );

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_SHIFT} scsh_rx_state_type;

  scsh_rx_state_type          state_r;
  scsh_rx_state_type          state_nxt;
  logic [9:0]                 sr_r;
  logic [9:0]                 sr_nxt;
  logic [scsh_pkg::CNT_W-1:0] cnt_r;
  logic [scsh_pkg::CNT_W-1:0] cnt_nxt;
  logic [3:0]                 nbits_r;
  logic [3:0]                 nbits_nxt;
  logic                       done_nxt;
  logic [7:0]                 data_nxt;
  logic                       fer_nxt;
  logic                       per_nxt;
  logic [3:0]                 last;

  assign last = par_en ? scsh_pkg::RX_LAST_PAR : scsh_pkg::RX_LAST_NOPAR;

  // start is a level, not an edge, so a held break keeps re-framing
  always_comb
  begin
    state_nxt = state_r;
    sr_nxt    = sr_r;
    cnt_nxt   = cnt_r;
    nbits_nxt = nbits_r;
    done_nxt  = 1'b0;
    data_nxt  = data_r;
    fer_nxt   = 1'b0;
    per_nxt   = 1'b0;
    unique case (state_r)
      RX_IDLE:
      begin
        nbits_nxt = '0;
        if (sync_mode)
          state_nxt = RX_SHIFT;
        else if (!rxd)
        begin
          cnt_nxt   = scsh_pkg::half_m1(baud_div);
          state_nxt = RX_START;
        end
      end
      RX_START:
      begin
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else if (!rxd)
        begin
          cnt_nxt   = scsh_pkg::full_m1(baud_div);
          state_nxt = RX_SHIFT;
        end
        else
          state_nxt = RX_IDLE; // glitch, not a start bit
      end
      RX_SHIFT:
      begin
        if (sync_mode)
        begin
          if (sync_rise)
          begin
            sr_nxt    = {rxd, sr_r[9:1]};
            nbits_nxt = nbits_r + 1'b1;
            if (nbits_r == scsh_pkg::SYNC_LAST)
            begin
              done_nxt  = 1'b1;
              data_nxt  = {rxd, sr_r[9:3]};
              nbits_nxt = '0;
            end
          end
        end
        else if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else
        begin
          sr_nxt    = {rxd, sr_r[9:1]};
          nbits_nxt = nbits_r + 1'b1;
          cnt_nxt   = scsh_pkg::full_m1(baud_div);
          if (nbits_r == last)
          begin
            done_nxt  = 1'b1;
            fer_nxt   = !rxd;
            state_nxt = RX_IDLE;
            if (par_en)
            begin
              data_nxt = sr_r[8:1];
              per_nxt  = scsh_pkg::parity_of(sr_r[8:1], par_odd) != sr_r[9];
            end
            else
              data_nxt = sr_r[9:2];
          end
        end
      end
    endcase
    // a partial character is thrown away
    if (clr || !rx_en)
    begin
      state_nxt = RX_IDLE;
      done_nxt  = 1'b0;
      fer_nxt   = 1'b0;
      per_nxt   = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= RX_IDLE;
      sr_r    <= '0;
      cnt_r   <= '0;
      nbits_r <= '0;
      done_r  <= 1'b0;
      data_r  <= '0;
      fer_r   <= 1'b0;
      per_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sr_r    <= sr_nxt;
      cnt_r   <= cnt_nxt;
      nbits_r <= nbits_nxt;
      done_r  <= done_nxt;
      data_r  <= data_nxt;
      fer_r   <= fer_nxt;
      per_r   <= per_nxt;
    end
  end
endmodule : scsh_rx

`default_nettype wire

// ---- design/scsh_top.sv ----
// serial channel top: register port, transmitter, pin muxing, power resets
// assumes lp_mode comes from logic on core_clk; rxd_i and sck_i are async
`default_nettype none

module scsh_top
  #(
    parameter logic [7:0] BAUD_DIV_RST = 8'h03
  )
  (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rstn,
    // register port
    input  wire logic [scsh_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [7:0]                    reg_rdata,
    // power state
    input  wire scsh_pkg::scsh_lp_type         lp_mode,
    // serial pins
    input  wire logic                          rxd_i,
    output logic                               txd_o,
    output logic                               txd_oe,
    input  wire logic                          sck_i,
    output logic                               sck_o,
    output logic                               sck_oe
  );

  typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} scsh_tx_state_type;

  scsh_pkg::scsh_mode_type    mode_r, mode_nxt;
  scsh_pkg::scsh_ctrl_type    ctrl_r, ctrl_nxt;
  scsh_pkg::scsh_stat_type    stat_r, stat_nxt;
  scsh_pkg::scsh_port_type    port_r, port_nxt;
  logic [7:0]                 baud_r, baud_nxt;
  logic [7:0]                 tdr_r, tdr_nxt;
  logic [7:0]                 rdr_r, rdr_nxt;
  logic                       mstop_r, mstop_nxt;
  logic [7:0]                 rdata_nxt;
  scsh_tx_state_type          tx_state_r, tx_state_nxt;
  logic [10:0]                tsr_r, tsr_nxt;
  logic [3:0]                 bitcnt_r, bitcnt_nxt;
  logic [scsh_pkg::CNT_W-1:0] tcnt_r, tcnt_nxt;
  logic                       sck_int_r, sck_int_nxt;
  logic                       txline_r, txline_nxt;
  logic [scsh_pkg::CNT_W-1:0] pulse_r, pulse_nxt;
  logic                       drv_r;
  logic                       txd_o_nxt, txd_oe_nxt, sck_o_nxt, sck_oe_nxt;
  logic                       rxd_s1_r, rxd_s2_r;
  logic                       sck_s1_r, sck_s2_r, sck_s3_r;
  logic                       tx_load, tx_end_ev;
  logic                       rx_done, rx_fer, rx_per;
  logic [7:0]                 rx_data;
  logic                       tx_rst, rx_rst, te, ext_clk, rx_err, can_start;
  logic                       sync_rise, sync_fall, drive_now;
  logic [3:0]                 async_last;

  // power and stop resets, start condition
  assign tx_rst    = mstop_r || scsh_pkg::tx_reset_on(lp_mode);
  assign rx_rst    = mstop_r || scsh_pkg::rx_reset_on(lp_mode);
  assign te        = ctrl_r.tx_enable_bit;
  assign ext_clk   = ctrl_r.clock_source_sel_hi;
  assign rx_err    = stat_r.overrun_flag || stat_r.framing_error_flag
                     || stat_r.parity_error_flag;
  assign can_start = te && !stat_r.tx_buffer_empty_flag
                     && !(mode_r.sync_mode && rx_err);
  assign async_last = mode_r.par_en ? scsh_pkg::ASYNC_LAST_PAR
                                    : scsh_pkg::ASYNC_LAST_NOPAR;
  // clock edges: own divider or the synchronised pin
  assign sync_rise = ext_clk ? (sck_s2_r && !sck_s3_r)
                             : (tx_state_r == TX_SYNC && !sck_int_r
                                && tcnt_r == '0);
  assign sync_fall = ext_clk ? (!sck_s2_r && sck_s3_r)
                             : (tx_state_r == TX_SYNC && sck_int_r
                                && tcnt_r == '0);
  assign drive_now = mode_r.sync_mode && !ext_clk;

  // receive side kept in its own module
  scsh_rx u_rx (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .clr       (rx_rst),
    .rx_en     (ctrl_r.rx_enable_bit),
    .sync_mode (mode_r.sync_mode),
    .par_en    (mode_r.par_en),
    .par_odd   (mode_r.par_odd),
    .baud_div  (baud_r),
    .rxd       (rxd_s2_r),
    .sync_rise (sync_rise && mode_r.sync_mode),
    .done_r    (rx_done),
    .data_r    (rx_data),
    .fer_r     (rx_fer),
    .per_r     (rx_per)
  );

  // register file; while stopped only the stop register answers
  always_comb
  begin
    mode_nxt  = mode_r;
    ctrl_nxt  = ctrl_r;
    stat_nxt  = stat_r;
    port_nxt  = port_r;
    baud_nxt  = baud_r;
    tdr_nxt   = tdr_r;
    rdr_nxt   = rdr_r;
    mstop_nxt = mstop_r;
    rdata_nxt = '0;
    if (reg_rd && (!mstop_r || reg_addr == scsh_pkg::OFS_MSTOP))
    begin
      unique case (reg_addr)
        scsh_pkg::OFS_MODE:  rdata_nxt = mode_r;
        scsh_pkg::OFS_BAUD:  rdata_nxt = baud_r;
        scsh_pkg::OFS_CTRL:  rdata_nxt = ctrl_r;
        scsh_pkg::OFS_TDATA: rdata_nxt = tdr_r;
        scsh_pkg::OFS_STAT:  rdata_nxt = stat_r;
        scsh_pkg::OFS_RDATA: rdata_nxt = rdr_r;
        scsh_pkg::OFS_PORT:  rdata_nxt = port_r;
        scsh_pkg::OFS_MSTOP: rdata_nxt = {7'h00, mstop_r};
      endcase
    end
    if (reg_wr && (!mstop_r || reg_addr == scsh_pkg::OFS_MSTOP))
    begin
      unique case (reg_addr)
        scsh_pkg::OFS_MODE:  mode_nxt = {reg_wdata[7], 1'h0, reg_wdata[5:4],
                                         4'h0};
        scsh_pkg::OFS_BAUD:  baud_nxt = reg_wdata;
        scsh_pkg::OFS_CTRL:  ctrl_nxt = {reg_wdata[7:4], 1'h0,
                                         reg_wdata[2:0]};
        scsh_pkg::OFS_TDATA: tdr_nxt  = reg_wdata;
        scsh_pkg::OFS_STAT:  stat_nxt = stat_r & {reg_wdata[7:2], 2'h0};
        scsh_pkg::OFS_RDATA: rdr_nxt  = rdr_r;     // read only
        scsh_pkg::OFS_PORT:  port_nxt = {reg_wdata[7:4], 4'h0};
        scsh_pkg::OFS_MSTOP: mstop_nxt = reg_wdata[0];
      endcase
    end
    // hardware sets come after the software clear so they win
    if (tx_load)
      stat_nxt.tx_buffer_empty_flag = 1'b1;
    if (tx_end_ev)
      stat_nxt.tx_end_flag = 1'b1;
    if (rx_done)
    begin
      if (stat_r.rx_full_flag)
        stat_nxt.overrun_flag = 1'b1;
      else
      begin
        rdr_nxt = rx_data;
        stat_nxt.rx_full_flag = 1'b1;
      end
      if (rx_fer)
        stat_nxt.framing_error_flag = 1'b1;
      if (rx_per)
        stat_nxt.parity_error_flag = 1'b1;
    end
    // receive enable plays no part here, so its clear keeps the flags
    if (!te)
    begin
      stat_nxt.tx_buffer_empty_flag = 1'b1;
      stat_nxt.tx_end_flag          = 1'b1;
    end
    if (tx_rst)
      tdr_nxt = '0;
    if (rx_rst)
      rdr_nxt = '0;
    if (tx_rst || rx_rst)
      stat_nxt = scsh_pkg::STAT_RST;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r    <= '0;
      ctrl_r    <= '0;
      stat_r    <= scsh_pkg::STAT_RST;
      port_r    <= '0;
      baud_r    <= BAUD_DIV_RST;
      tdr_r     <= '0;
      rdr_r     <= '0;
      mstop_r   <= scsh_pkg::MSTOP_RST[0];
      reg_rdata <= '0;
    end
    else
    begin
      mode_r    <= mode_nxt;
      ctrl_r    <= ctrl_nxt;
      stat_r    <= stat_nxt;
      port_r    <= port_nxt;
      baud_r    <= baud_nxt;
      tdr_r     <= tdr_nxt;
      rdr_r     <= rdr_nxt;
      mstop_r   <= mstop_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // transmitter; a frame ends through idle so reload needs no copy
  always_comb
  begin
    tx_state_nxt = tx_state_r;
    tsr_nxt      = tsr_r;
    bitcnt_nxt   = bitcnt_r;
    tcnt_nxt     = tcnt_r;
    sck_int_nxt  = sck_int_r;
    txline_nxt   = txline_r;
    tx_load      = 1'b0;
    tx_end_ev    = 1'b0;
    unique case (tx_state_r)
      TX_IDLE:
      begin
        sck_int_nxt = 1'b1;
        if (can_start)
        begin
          tx_load    = 1'b1;
          bitcnt_nxt = '0;
          if (mode_r.sync_mode)
          begin
            tsr_nxt      = {3'h7, tdr_r};
            txline_nxt   = tdr_r[0];
            sck_int_nxt  = ext_clk;
            tcnt_nxt     = scsh_pkg::half_m1(baud_r);
            tx_state_nxt = TX_SYNC;
          end
          else
          begin
            tsr_nxt      = {1'b1, mode_r.par_en ?
                            scsh_pkg::parity_of(tdr_r, mode_r.par_odd) : 1'b1,
                            tdr_r, 1'b0};
            txline_nxt   = 1'b0;
            tcnt_nxt     = scsh_pkg::full_m1(baud_r);
            tx_state_nxt = TX_ASYNC;
          end
        end
      end
      TX_ASYNC:
      begin
        if (tcnt_r != '0)
          tcnt_nxt = tcnt_r - 1'b1;
        else if (bitcnt_r == async_last)
        begin
          tx_state_nxt = TX_IDLE;
          tx_end_ev    = !can_start;
        end
        else
        begin
          tsr_nxt    = {1'b1, tsr_r[10:1]};
          txline_nxt = tsr_r[1];
          bitcnt_nxt = bitcnt_r + 1'b1;
          tcnt_nxt   = scsh_pkg::full_m1(baud_r);
        end
      end
      TX_SYNC:
      begin
        if (tcnt_r != '0)
          tcnt_nxt = tcnt_r - 1'b1;
        if (sync_rise)
        begin
          sck_int_nxt = 1'b1;
          tcnt_nxt    = scsh_pkg::half_m1(baud_r);
          bitcnt_nxt  = bitcnt_r + 1'b1;
          if (bitcnt_r == scsh_pkg::SYNC_LAST && !can_start)
          begin
            tx_state_nxt = TX_IDLE; // line keeps the last bit
            tx_end_ev    = 1'b1;
          end
        end
        else if (sync_fall)
        begin
          if (bitcnt_r == scsh_pkg::SYNC_BITS)
          begin
            tx_state_nxt = TX_IDLE;
            tx_end_ev    = !can_start;
          end
          else
          begin
            sck_int_nxt = 1'b0;
            tcnt_nxt    = scsh_pkg::half_m1(baud_r);
            tsr_nxt     = {1'b1, tsr_r[10:1]};
            txline_nxt  = tsr_r[0];
          end
        end
      end
    endcase
    // abort at once, whatever is on the line; idle level is mark
    if (!te || tx_rst)
    begin
      tx_state_nxt = TX_IDLE;
      tsr_nxt      = '1;
      bitcnt_nxt   = '0;
      tcnt_nxt     = '0;
      sck_int_nxt  = 1'b1;
      txline_nxt   = 1'b1;
      tx_load      = 1'b0;
      tx_end_ev    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_state_r <= TX_IDLE;
      tsr_r      <= '1;
      bitcnt_r   <= '0;
      tcnt_r     <= '0;
      sck_int_r  <= 1'b1;
      txline_r   <= 1'b1;
    end
    else
    begin
      tx_state_r <= tx_state_nxt;
      tsr_r      <= tsr_nxt;
      bitcnt_r   <= bitcnt_nxt;
      tcnt_r     <= tcnt_nxt;
      sck_int_r  <= sck_int_nxt;
      txline_r   <= txline_nxt;
    end
  end

  // pin muxing and the clock pin hand-back pulse
  always_comb
  begin
    pulse_nxt  = pulse_r;
    txd_o_nxt  = te ? txline_r : port_r.port_data_bit;
    txd_oe_nxt = te ? 1'b1 : port_r.txd_dir;
    sck_o_nxt  = port_r.sck_data;
    sck_oe_nxt = port_r.sck_dir;
    if (drive_now)
    begin
      sck_o_nxt  = sck_int_r;
      sck_oe_nxt = 1'b1;
      pulse_nxt  = '0;
    end
    else if (drv_r && !ext_clk)
    begin
      pulse_nxt  = scsh_pkg::half_m1(baud_r);
      sck_o_nxt  = 1'b0;
      sck_oe_nxt = 1'b1;
    end
    else if (pulse_r != '0)
    begin
      pulse_nxt  = pulse_r - 1'b1;
      sck_o_nxt  = 1'b0;
      sck_oe_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pulse_r <= '0;
      drv_r   <= 1'b0;
      txd_o   <= 1'b0;
      txd_oe  <= 1'b0;
      sck_o   <= 1'b0;
      sck_oe  <= 1'b0;
    end
    else
    begin
      pulse_r <= pulse_nxt;
      drv_r   <= drive_now;
      txd_o   <= txd_o_nxt;
      txd_oe  <= txd_oe_nxt;
      sck_o   <= sck_o_nxt;
      sck_oe  <= sck_oe_nxt;
    end
  end

  // pin synchronisers; only the second stage onward is looked at
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      sck_s1_r <= 1'b1;
      sck_s2_r <= 1'b1;
      sck_s3_r <= 1'b1;
    end
    else
    begin
      rxd_s1_r <= rxd_i;
      rxd_s2_r <= rxd_s1_r;
      sck_s1_r <= sck_i;
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
    end
  end
endmodule : scsh_top

`default_nettype wire

// ---- bench/scsh_top_sva.sv ----
// checker: register port and transmit pin relations of scsh_top
// assumes software follows the register port protocol
`default_nettype none

module scsh_top_sva
  (
    // clock and reset
    input wire logic                        core_clk,
    input wire logic                        rstn,
    // register port
    input wire logic [scsh_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_rdata,
    // power and pins
    input wire scsh_pkg::scsh_lp_type       lp_mode,
    input wire logic                        txd_o,
    input wire logic                        txd_oe,
    input wire logic                        sck_oe
  );
  logic       mstop_r;
  logic       ten_r;
  logic [3:0] prt_r;

  // mirror of stop, transmit enable and port bits; stop drops writes
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      mstop_r <= 1'b1;
      ten_r   <= 1'b0;
      prt_r   <= 4'h0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == scsh_pkg::OFS_MSTOP)
        mstop_r <= reg_wdata[0];
      if (!mstop_r && reg_addr == scsh_pkg::OFS_CTRL)
        ten_r <= reg_wdata[5];
      if (!mstop_r && reg_addr == scsh_pkg::OFS_PORT)
        prt_r <= reg_wdata[7:4];
    end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  reset_pins_a: assert property ($rose(rstn) |-> !txd_oe && !sck_oe)
    else $error("pins driven after reset");
  stop_read_a: assert property (
    reg_rd && mstop_r && reg_addr != scsh_pkg::OFS_MSTOP |=> reg_rdata == 0)
    else $error("register open in stop");
  port_read_a: assert property (
    reg_rd && !mstop_r && reg_addr == scsh_pkg::OFS_PORT
    |=> reg_rdata == {prt_r, 4'h0})
    else $error("port read wrong");
  port_pin_a: assert property (
    (!ten_r && $stable(prt_r))[*3]
    |-> txd_oe == prt_r[1] && (txd_o == prt_r[0] || !prt_r[1]))
    else $error("pin not under port");
  tx_off_a: assert property (
    $fell(ten_r) |-> ##[1:2] txd_oe == prt_r[1] && txd_o == prt_r[0])
    else $error("transmitter kept pin");
  empty_off_a: assert property (
    reg_rd && reg_addr == scsh_pkg::OFS_STAT && !mstop_r && !ten_r
    && !$past(ten_r, 2) |=> reg_rdata[7] && reg_rdata[2])
    else $error("empty flag clear while off");
  lp_stat_a: assert property (
    reg_rd && reg_addr == scsh_pkg::OFS_STAT && !mstop_r
    && lp_mode == scsh_pkg::LP_SW_STANDBY
    && $past(lp_mode) == scsh_pkg::LP_SW_STANDBY
    |=> reg_rdata == scsh_pkg::STAT_RST)
    else $error("status not reset in standby");
endmodule : scsh_top_sva

bind scsh_top scsh_top_sva chk_u (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lp_mode(lp_mode),
  .txd_o(txd_o), .txd_oe(txd_oe), .sck_oe(sck_oe));

`default_nettype wire

// ---- bench/scsh_peer.sv ----
// line peer: remote transmitter resting at mark or holding a break
// assumes the bench steers the break request
`default_nettype none

module scsh_peer
  (
    // control
    input  wire logic brk,
    // line
    output logic      rxd,
    output logic      sck
  );
  timeunit 1ns;
  timeprecision 1ps;

  // break is all zeros; otherwise mark. clock line pulled up, no frames
  assign rxd = !brk;
  assign sck = 1'b1;
endmodule : scsh_peer

`default_nettype wire

// ---- bench/scsh_tb_top.sv ----
// bench top: scenarios through the register port, peer on the lines
// assumes package, design, checker and peer compiled before
`default_nettype none

module scsh_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  core_clk, rxd_i, sck_i, txd_o, txd_oe, sck_o, sck_oe;
  logic                  rstn = 1'b0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  logic                  brk = 1'b0;
  logic [2:0]            reg_addr = 3'h0;
  logic [7:0]            reg_wdata = 8'h00;
  logic [7:0]            reg_rdata, rv;
  logic [9:0]            fr;
  scsh_pkg::scsh_lp_type lp_mode = scsh_pkg::LP_ACTIVE;
  int                    n_mismatch = 0;
  int                    n_checks = 0;
  int                    cyc = 0;

  scsh_top dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lp_mode(lp_mode), .rxd_i(rxd_i),
    .txd_o(txd_o), .txd_oe(txd_oe), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe));
  scsh_peer peer_u (.brk(brk), .rxd(rxd_i), .sck(sck_i));

  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // hang guard, far past the run's length
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h, not %h", $time, seen, exp);
    end
  endtask : chk

  // settle past the edge so sampled pins are stable
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd

  task automatic t_mstop();
    rd(scsh_pkg::OFS_STAT);
    chk(rv, 8'h00);
    wr(scsh_pkg::OFS_MSTOP, 8'h00);
    rd(scsh_pkg::OFS_STAT);
    chk(rv, scsh_pkg::STAT_RST);
    $display("stop test over");
  endtask : t_mstop

  task automatic t_port();
    wr(scsh_pkg::OFS_PORT, 8'h30);
    tick(3);
    chk({6'h0, txd_oe, txd_o}, 8'h03);
    wr(scsh_pkg::OFS_PORT, 8'h20);
    rd(scsh_pkg::OFS_PORT);
    chk(rv, 8'h20);
    chk({6'h0, txd_oe, txd_o}, 8'h02);
    $display("port test over");
  endtask : t_port

  // two queued bytes, the second overwritten, then abort mid-frame
  task automatic t_tx();
    wr(scsh_pkg::OFS_CTRL, 8'h20);
    wr(scsh_pkg::OFS_TDATA, 8'h55);
    wr(scsh_pkg::OFS_STAT, 8'h7f);
    wr(scsh_pkg::OFS_TDATA, 8'h11);
    wr(scsh_pkg::OFS_STAT, 8'h7f);
    wr(scsh_pkg::OFS_TDATA, 8'ha3);
    tick(70);
    for (int i = 0; i < 40 && txd_o !== 1'b0; i++)
      tick(1);
    tick(4);
    for (int k = 0; k < 10; k++)
    begin
      fr[k] = txd_o;
      tick(8);
    end
    chk(fr[8:1], 8'ha3);
    chk({6'h0, fr[9], fr[0]}, 8'h02);
    wr(scsh_pkg::OFS_TDATA, 8'h0f);
    wr(scsh_pkg::OFS_STAT, 8'h7f);
    tick(20);
    wr(scsh_pkg::OFS_CTRL, 8'h00);
    tick(2);
    chk({6'h0, txd_oe, txd_o}, 8'h02);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h84, 8'h84);
    $display("transmit test over");
  endtask : t_tx

  task automatic t_brk();
    wr(scsh_pkg::OFS_CTRL, 8'h10);
    brk <= 1'b1;
    tick(200);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h10, 8'h10);
    wr(scsh_pkg::OFS_STAT, 8'hef);
    tick(200);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h10, 8'h10);
    wr(scsh_pkg::OFS_CTRL, 8'h00);
    brk <= 1'b0;
    tick(200);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h10, 8'h10);
    $display("break test over");
  endtask : t_brk

  // error flags left set from the break hold the clocked transmitter
  task automatic t_sync();
    wr(scsh_pkg::OFS_MODE, 8'h80);
    wr(scsh_pkg::OFS_CTRL, 8'h20);
    wr(scsh_pkg::OFS_TDATA, 8'h3c);
    wr(scsh_pkg::OFS_STAT, 8'h7f);
    tick(40);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h80, 8'h00);
    wr(scsh_pkg::OFS_STAT, 8'hc7);
    tick(4);
    rd(scsh_pkg::OFS_STAT);
    chk(rv & 8'h80, 8'h80);
    $display("sync test over");
  endtask : t_sync

  task automatic t_lp();
    tick(80);
    wr(scsh_pkg::OFS_CTRL, 8'h00);
    lp_mode <= scsh_pkg::LP_SW_STANDBY;
    tick(3);
    rd(scsh_pkg::OFS_STAT);
    chk(rv, scsh_pkg::STAT_RST);
    @(posedge core_clk);
    lp_mode <= scsh_pkg::LP_ACTIVE;
    wr(scsh_pkg::OFS_CTRL, 8'h20);
    rd(scsh_pkg::OFS_STAT);
    chk(rv, scsh_pkg::STAT_RST);
    chk({6'h0, txd_oe, txd_o}, 8'h03);
    wr(scsh_pkg::OFS_TDATA, 8'h5a);
    wr(scsh_pkg::OFS_STAT, 8'h7f);
    tick(80);
    wr(scsh_pkg::OFS_MODE, 8'h00);
    tick(1);
    chk({6'h0, sck_oe, sck_o}, 8'h02);
    wr(scsh_pkg::OFS_MODE, 8'h80);
    wr(scsh_pkg::OFS_CTRL, 8'h02);
    tick(1);
    chk({6'h0, sck_oe, sck_o}, 8'h00);
    $display("low power test over");
  endtask : t_lp

  // main sequence
  initial
  begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    t_mstop();
    t_port();
    t_tx();
    t_brk();
    t_sync();
    t_lp();
    print_verdict();
  end
endmodule : scsh_tb_top

`default_nettype wire
